// ===== rtl/adcts_pkg.sv
package adcts_pkg;

   // Register indices (printed offsets; byte address is four times these)
   localparam logic [15:0] ADCTS_IDX_PCH    = 16'h1D1F;
   localparam logic [15:0] ADCTS_IDX_PRE    = 16'h1D24;
   localparam logic [15:0] ADCTS_IDX_STAT   = 16'h1D2A;
   localparam logic [15:0] ADCTS_IDX_REF    = 16'h1D2B;
   localparam logic [15:0] ADCTS_IDX_CLK    = 16'h1D2D;
   localparam logic [15:0] ADCTS_IDX_CTL    = 16'h1D29;
   localparam logic [15:0] ADCTS_IDX_LIM    = 16'h1D30;
   localparam logic [15:0] ADCTS_IDX_RUN    = 16'h1D31;

   // Status field positions
   localparam int ADCTS_ST_OVF   = 7;
   localparam int ADCTS_ST_UPPER = 6;
   localparam int ADCTS_ST_LOWER = 5;
   localparam int ADCTS_ST_COMPUTATION_UPDATE_FLAG  = 4;

   // Control register field positions
   localparam int ADCTS_CTL_SOI  = 3;
   localparam int ADCTS_CTL_DOUBLE_SAMPLE_ENABLE = 4;
   localparam int ADCTS_CTL_CONTINUOUS_ENABLE = 5;
   localparam int ADCTS_CTL_RC   = 6;

   // Run register field positions
   localparam int ADCTS_RUN_GO   = 0;

   // Reset values
   localparam logic [7:0]  ADCTS_RST_BYTE = 8'h00;
   localparam logic [15:0] ADCTS_RST_HALF = 16'h0000;

   // Stage time in converter clocks minus one (simplified sequencer)
   localparam logic [3:0]  ADCTS_STAGE_TICKS = 4'h3;

   // Threshold interrupt modes
   typedef enum logic [2:0] {
      ADCTS_TM_NEVER = 3'b000,
      ADCTS_TM_LT_LO = 3'b001,
      ADCTS_TM_GE_LO = 3'b010,
      ADCTS_TM_INSIDE = 3'b011,
      ADCTS_TM_OUTSIDE = 3'b100,
      ADCTS_TM_LE_UP = 3'b101,
      ADCTS_TM_GT_UP = 3'b110,
      ADCTS_TM_ALWAYS = 3'b111
   } adcts_tmode_type;

   // Cycle-stage codes
   typedef enum logic [2:0] {
      ADCTS_S_IDLE = 3'b000,
      ADCTS_S_PRE1 = 3'b001,
      ADCTS_S_ACQ1 = 3'b010,
      ADCTS_S_CNV1 = 3'b011,
      ADCTS_S_SUSP = 3'b100,
      ADCTS_S_PRE2 = 3'b101,
      ADCTS_S_ACQ2 = 3'b110,
      ADCTS_S_CNV2 = 3'b111
   } adcts_stage_type;

   // Reference select codes
   localparam logic [1:0] ADCTS_REF_VDD = 2'b00;
   localparam logic [1:0] ADCTS_REF_EXT = 2'b10;
   localparam logic [1:0] ADCTS_REF_FIX = 2'b11;

   // Channel codes
   localparam logic [5:0] ADCTS_CH_FIX2  = 6'h3F;
   localparam logic [5:0] ADCTS_CH_FIX1  = 6'h3E;
   localparam logic [5:0] ADCTS_CH_RSV   = 6'h3D;
   localparam logic [5:0] ADCTS_CH_DAC   = 6'h3C;
   localparam logic [5:0] ADCTS_CH_TEMP  = 6'h3B;
   localparam logic [5:0] ADCTS_CH_GND   = 6'h3A;
   localparam logic [5:0] ADCTS_CH_GUARD = 6'h03;

endpackage : adcts_pkg

// ===== rtl/adcts_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Mode 000 never interrupts, 111 always
// - 001 below lower; 010 at/above lower
// - 011 strictly inside the window
// - 100 strictly outside the window
// - 101 at/below upper; 110 above upper
// - Overflow bit set by hardware, read-only
// - Bit 6 shows error above upper limit
// - Bit 5 shows error below lower limit
// - Update bit set by hardware, software clears
// - Clear ignored while stage is suspended
// - Stage field codes for both samples
// - Code 100 while suspended between samples
// - Suspend only with double sampling, non-continuous
// - Converter clock is oscillator over 2(n+1)
// - Divider ignored when internal RC chosen
// - Reference codes: supply, external, fixed
// - Channel codes for internal sources decoded
// - Reserved channel codes connect nothing
// - Continuous with stop clears start on hit
module adcts_top
   import adcts_pkg::*;
#(
   parameter bit LARGE_PKG = 1'b1   // Largest package variant
)(
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        reset,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic      [31:0] hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Computation unit inputs (same clock)
   input  wire logic [15:0] error_value,
   input  wire logic        calc_done,
   input  wire logic        calc_start,
   input  wire logic        overflow_evt,
   input  wire logic        conv_trig,
   input  wire logic        rc_clk_tick,
   // Converter side outputs
   output logic             threshold_irq,
   output logic             conv_clk,
   output logic [1:0]       ref_sel,
   output logic [5:0]       chan_sel,
   output logic             chan_valid
);

   // Register state
   logic [5:0]  pch_r;          // Positive channel code
   logic [12:0] pre_r;          // Precharge time, stored only
   logic [1:0]  positive_reference_select_r;         // Positive reference select
   logic [5:0]  cdiv_r;         // Clock divider n
   logic [6:0]  ctl_r;          // Mode, stop, double_sample_enable, continuous_enable, rc
   logic [15:0] upper_limit_r;  // Upper limit
   logic [15:0] lower_limit_r;  // Lower limit
   logic        go_r;           // Conversion start
   logic        ovf_r;          // Overflow flag
   logic        upper_r;        // Above upper flag
   logic        lower_r;        // Below lower flag
   logic        computation_update_flag_r;         // Computation update flag
   adcts_stage_type stage_r;    // Cycle stage
   logic [3:0]  stick_r;        // Stage tick counter
   logic [5:0]  div_cnt_r;      // Divider count
   logic        tick_r;         // Converter clock tick

   // Bus pipeline
   logic        wr_pend_r;      // Write data phase pending
   logic [15:0] wr_idx_r;       // Latched word index

   adcts_tmode_type threshold_irq_mode;
   logic double_sample_enable, continuous_enable;
   logic stop_on_interrupt, internal_rc_conv_clock;
   logic signed [15:0] err_s, up_s, lo_s;
   logic above_upper, below_lower, irq_hit;
   logic addr_ph;
   logic [15:0] addr_idx;
   logic computation_update_flag_clr;

   assign threshold_irq_mode     = adcts_tmode_type'(ctl_r[2:0]);
   assign stop_on_interrupt      = ctl_r[ADCTS_CTL_SOI];
   assign double_sample_enable   = ctl_r[ADCTS_CTL_DOUBLE_SAMPLE_ENABLE];
   assign continuous_enable      = ctl_r[ADCTS_CTL_CONTINUOUS_ENABLE];
   assign internal_rc_conv_clock = ctl_r[ADCTS_CTL_RC];
   assign err_s = error_value;
   assign up_s  = upper_limit_r;
   assign lo_s  = lower_limit_r;

   // Signed compares of the error value
   assign above_upper = err_s > up_s;
   assign below_lower = err_s < lo_s;

   // Threshold decision per mode
   function automatic logic adcts_hit(input adcts_tmode_type m,
                                      input logic au, input logic bl,
                                      input logic gtl, input logic ltu);
      logic r;
      r = 1'b0;
      case (m)
         ADCTS_TM_NEVER:   r = 1'b0;
         ADCTS_TM_ALWAYS:  r = 1'b1;
         ADCTS_TM_LT_LO:   r = bl;
         ADCTS_TM_GE_LO:   r = !bl;
         ADCTS_TM_INSIDE:  r = gtl && ltu;
         ADCTS_TM_OUTSIDE: r = bl || au;
         ADCTS_TM_LE_UP:   r = !au;
         ADCTS_TM_GT_UP:   r = au;
         default:          r = 1'b0;
      endcase
      return r;
   endfunction : adcts_hit

   assign irq_hit = adcts_hit(threshold_irq_mode, above_upper, below_lower,
                              err_s > lo_s, err_s < up_s);

   // Bus address phase decode
   assign addr_ph  = hsel && htrans[1] && hready;
   assign addr_idx = haddr[17:2];

   // Software clear of the update flag this cycle
   assign computation_update_flag_clr = wr_pend_r && (wr_idx_r == ADCTS_IDX_STAT)
                     && !hwdata[ADCTS_ST_COMPUTATION_UPDATE_FLAG];

   // Zero wait states, always OKAY
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_r <= 1'b0;
         wr_idx_r  <= ADCTS_RST_HALF;
      end else begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
         wr_pend_r <= addr_ph && hwrite;
         if (addr_ph) begin
            wr_idx_r <= addr_idx;
         end
      end
   end

   // Read data registered at the address phase
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         hrdata <= 32'h0000_0000;
      end else if (addr_ph && !hwrite) begin
         case (addr_idx)
            ADCTS_IDX_PCH:  hrdata <= {26'h0, pch_r};
            ADCTS_IDX_PRE:  hrdata <= {19'h0, pre_r};
            ADCTS_IDX_STAT: hrdata <= {24'h0, ovf_r, upper_r, lower_r,
                                       computation_update_flag_r, 1'b0, stage_r};
            ADCTS_IDX_REF:  hrdata <= {30'h0, positive_reference_select_r};
            ADCTS_IDX_CLK:  hrdata <= {26'h0, cdiv_r};
            ADCTS_IDX_CTL:  hrdata <= {25'h0, ctl_r};
            ADCTS_IDX_LIM:  hrdata <= {upper_limit_r, lower_limit_r};
            ADCTS_IDX_RUN:  hrdata <= {31'h0, go_r};
            default:        hrdata <= 32'h0000_0000;
         endcase
      end
   end

   // Software-written configuration
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         pch_r         <= ADCTS_RST_BYTE[5:0];
         pre_r         <= ADCTS_RST_HALF[12:0];
         positive_reference_select_r        <= ADCTS_RST_BYTE[1:0];
         cdiv_r        <= ADCTS_RST_BYTE[5:0];
         ctl_r         <= ADCTS_RST_BYTE[6:0];
         upper_limit_r <= ADCTS_RST_HALF;
         lower_limit_r <= ADCTS_RST_HALF;
      end else if (wr_pend_r) begin
         case (wr_idx_r)
            ADCTS_IDX_PCH: pch_r  <= hwdata[5:0];
            ADCTS_IDX_PRE: pre_r  <= hwdata[12:0];
            ADCTS_IDX_REF: positive_reference_select_r <= hwdata[1:0];
            ADCTS_IDX_CLK: cdiv_r <= hwdata[5:0];
            ADCTS_IDX_CTL: ctl_r  <= hwdata[6:0];
            ADCTS_IDX_LIM: begin
               upper_limit_r <= hwdata[31:16];
               lower_limit_r <= hwdata[15:0];
            end
            default: ;
         endcase
      end
   end

   // Start bit: software sets, hardware stops on hit
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         go_r <= 1'b0;
      end else if (calc_done && continuous_enable && stop_on_interrupt
                   && irq_hit) begin
         go_r <= 1'b0;
      end else if (wr_pend_r && wr_idx_r == ADCTS_IDX_RUN) begin
         go_r <= hwdata[ADCTS_RUN_GO];
      end else if (calc_done && !continuous_enable) begin
         go_r <= 1'b0;  // Single run ends
      end
   end

   // Status flags; hardware set beats software clear
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ovf_r   <= 1'b0;
         upper_r <= 1'b0;
         lower_r <= 1'b0;
         computation_update_flag_r  <= 1'b0;
      end else begin
         if (overflow_evt) begin
            ovf_r <= 1'b1;
         end
         if (calc_done) begin
            upper_r <= above_upper;
            lower_r <= below_lower;
         end
         if (calc_start || calc_done || overflow_evt) begin
            computation_update_flag_r <= 1'b1;
         end else if (computation_update_flag_clr && stage_r != ADCTS_S_SUSP) begin
            computation_update_flag_r <= 1'b0;
         end
      end
   end

   // Interrupt pulse at computation end
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         threshold_irq <= 1'b0;
      end else begin
         threshold_irq <= calc_done && irq_hit;
      end
   end

   // Divider: toggle every n+1 oscillator clocks
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         div_cnt_r <= 6'h00;
         conv_clk  <= 1'b0;
         tick_r    <= 1'b0;
      end else if (internal_rc_conv_clock) begin
         div_cnt_r <= 6'h00;
         tick_r    <= rc_clk_tick;
         conv_clk  <= rc_clk_tick;
      end else if (div_cnt_r >= cdiv_r) begin
         div_cnt_r <= 6'h00;
         conv_clk  <= !conv_clk;
         tick_r    <= !conv_clk;
      end else begin
         div_cnt_r <= div_cnt_r + 6'h01;
         tick_r    <= 1'b0;
      end
   end

   // Stage sequencer on converter ticks
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         stage_r <= ADCTS_S_IDLE;
         stick_r <= 4'h0;
      end else begin
         case (stage_r)
            ADCTS_S_IDLE: begin
               stick_r <= 4'h0;
               if (go_r && conv_trig) begin
                  stage_r <= ADCTS_S_PRE1;
               end
            end
            ADCTS_S_SUSP: begin
               if (conv_trig) begin
                  stage_r <= ADCTS_S_PRE2;
               end
            end
            default: begin
               if (tick_r) begin
                  if (stick_r == ADCTS_STAGE_TICKS) begin
                     stick_r <= 4'h0;
                     case (stage_r)
                        ADCTS_S_PRE1: stage_r <= ADCTS_S_ACQ1;
                        ADCTS_S_ACQ1: stage_r <= ADCTS_S_CNV1;
                        ADCTS_S_CNV1: begin
                           if (!double_sample_enable) begin
                              stage_r <= ADCTS_S_IDLE;
                           end else if (continuous_enable) begin
                              stage_r <= ADCTS_S_PRE2;
                           end else begin
                              stage_r <= ADCTS_S_SUSP;
                           end
                        end
                        ADCTS_S_PRE2: stage_r <= ADCTS_S_ACQ2;
                        ADCTS_S_ACQ2: stage_r <= ADCTS_S_CNV2;
                        default:      stage_r <= ADCTS_S_IDLE;
                     endcase
                  end else begin
                     stick_r <= stick_r + 4'h1;
                  end
               end
            end
         endcase
      end
   end

   // Analog select decode
   always_ff @(posedge mclk or posedge reset) begin
      if (reset) begin
         ref_sel    <= ADCTS_REF_VDD;
         chan_sel   <= 6'h00;
         chan_valid <= 1'b1;
      end else begin
         ref_sel  <= (positive_reference_select_r == 2'b01) ? ADCTS_REF_VDD : positive_reference_select_r;
         chan_sel <= pch_r;
         if (pch_r == ADCTS_CH_RSV || (pch_r <= 6'h39 && pch_r >= 6'h18)
             || (pch_r <= 6'h0B && pch_r >= 6'h06)) begin
            chan_valid <= 1'b0;
         end else if (pch_r == 6'h16 || pch_r == 6'h17
                      || (pch_r >= 6'h0C && pch_r <= 6'h0F)) begin
            chan_valid <= LARGE_PKG;
         end else begin
            chan_valid <= 1'b1;
         end
      end
   end

   // Checks; a bad decode of mode 000 or 111 shows up as a wrong pulse here
   a_never_mode: assert property (
      @(posedge mclk) disable iff (reset)
      threshold_irq_mode == ADCTS_TM_NEVER && calc_done |=> !threshold_irq)
      else $error("irq in never mode");
   a_always_mode: assert property (
      @(posedge mclk) disable iff (reset)
      threshold_irq_mode == ADCTS_TM_ALWAYS && calc_done |=> threshold_irq)
      else $error("no irq in always mode");
   a_upper_flag: assert property (
      @(posedge mclk) disable iff (reset)
      calc_done |=> upper_r == $past(above_upper))
      else $error("upper flag wrong");
   a_lower_flag: assert property (
      @(posedge mclk) disable iff (reset)
      calc_done |=> lower_r == $past(below_lower))
      else $error("lower flag wrong");
   a_ovf_sticky: assert property (
      @(posedge mclk) disable iff (reset)
      overflow_evt |=> ovf_r [*2])
      else $error("overflow lost");
   a_computation_update_flag_hold: assert property (
      @(posedge mclk) disable iff (reset)
      computation_update_flag_r && stage_r == ADCTS_S_SUSP |=> computation_update_flag_r)
      else $error("update flag cleared in suspend");
   a_susp_cond: assert property (
      @(posedge mclk) disable iff (reset)
      stage_r != ADCTS_S_SUSP ##1 stage_r == ADCTS_S_SUSP
      |-> double_sample_enable && !continuous_enable)
      else $error("bad suspend");
   a_stop_go: assert property (
      @(posedge mclk) disable iff (reset)
      calc_done && continuous_enable && stop_on_interrupt && irq_hit
      |=> !go_r) else $error("go not stopped");
   // Reserved reference code must never reach the analog switch
   a_ref_reserved: assert property (
      @(posedge mclk) disable iff (reset)
      positive_reference_select_r == 2'b01 |=> ref_sel == ADCTS_REF_VDD)
      else $error("reserved reference passed on");
   a_rc_bypass: assert property (
      @(posedge mclk) disable iff (reset)
      internal_rc_conv_clock |=> div_cnt_r == 6'h00
      && conv_clk == $past(rc_clk_tick))
      else $error("divider active on RC clock");
   // Main scenarios
   c_irq: cover property (@(posedge mclk) disable iff (reset)
      threshold_irq);
   c_susp: cover property (@(posedge mclk) disable iff (reset)
      stage_r == ADCTS_S_SUSP);
   c_stage2: cover property (@(posedge mclk) disable iff (reset)
      stage_r == ADCTS_S_CNV2);
   c_computation_update_flag_refused: cover property (@(posedge mclk) disable iff (reset)
      computation_update_flag_clr && stage_r == ADCTS_S_SUSP);
   c_stop_hit: cover property (@(posedge mclk) disable iff (reset)
      calc_done && continuous_enable && stop_on_interrupt && irq_hit);

endmodule : adcts_top

// ===== testbench/adc_threshold_status_control_bench.sv
`timescale 1ns/1ps
module adc_threshold_status_control_bench
   import adcts_pkg::*;
;
   // Clock, reset and bus
   logic        mclk;
   logic        reset;
   logic        hsel;
   logic [31:0] haddr;
   logic [1:0]  htrans;
   logic        hwrite;
   logic [2:0]  hsize;
   logic [31:0] hwdata;
   logic [31:0] hrdata;
   logic        hreadyout;
   logic        hresp;
   // Computation unit side
   logic [15:0] error_value;
   logic        calc_done;
   logic        calc_start;
   logic        overflow_evt;
   logic        conv_trig;
   logic        rc_clk_tick;
   logic        threshold_irq;
   logic        conv_clk;
   logic [1:0]  ref_sel;
   logic [5:0]  chan_sel;
   logic        chan_valid;
   // Bench bookkeeping
   int          error_cnt;
   int          n_compared;
   int          cyc;
   int          p;
   logic [31:0] rd;
   // Limits: lower -10, upper 20, signed
   localparam logic [15:0] LO = 16'hFFF6;
   localparam logic [15:0] UP = 16'h0014;
   // Values straddling both limits and the sign boundary
   logic [15:0] tv [7] = '{16'h8000, 16'hFFF5, 16'hFFF6, 16'h0000,
                           16'h0014, 16'h0015, 16'h7FFF};
   // Channel codes and whether a real input answers
   logic [5:0]  cc [8] = '{6'h3F, 6'h3D, 6'h3C, 6'h3A, 6'h20,
                           6'h08, 6'h17, 6'h03};
   logic        cv [8] = '{1'b1, 1'b0, 1'b1, 1'b1, 1'b0,
                           1'b0, 1'b1, 1'b1};

   adcts_top #(.LARGE_PKG(1'b1)) uut (
      .mclk(mclk), .reset(reset), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .error_value(error_value), .calc_done(calc_done),
      .calc_start(calc_start), .overflow_evt(overflow_evt),
      .conv_trig(conv_trig), .rc_clk_tick(rc_clk_tick),
      .threshold_irq(threshold_irq), .conv_clk(conv_clk),
      .ref_sel(ref_sel), .chan_sel(chan_sel), .chan_valid(chan_valid));

   // 40 MHz system clock
   initial begin
      mclk = 1'b0;
      forever #12.5 mclk = ~mclk;
   end

   // Free-running RC stand-in, so the RC path is exercised
   always @(posedge mclk) begin
      rc_clk_tick <= ~rc_clk_tick;
   end

   // Hang guard; tests need several hundred cycles
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         error_cnt++;
         $display("ERROR at %0t: timeout", $time);
         print_verdict();
      end
   end

   // Verdict and end of run
   task automatic print_verdict();
      $display("Compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : print_verdict

   // Compare and count
   task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                      input string what);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR at %0t: %s got %h exp %h", $time, what, got, exp);
      end
   endtask : chk

   // Single AHB-Lite word transfer; waits on hready, never on a count
   task automatic xfer(input logic [15:0] idx, input logic wr,
                       input logic [31:0] wd);
      @(posedge mclk);
      hsel   <= 1'b1;
      htrans <= 2'b10;
      haddr  <= {14'h0, idx, 2'b00};
      hwrite <= wr;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      htrans <= 2'b00;
      hwdata <= wd;
      @(posedge mclk);
      while (hreadyout !== 1'b1) @(posedge mclk);
      rd = hrdata;
   endtask : xfer

   // One computation result with the given error value
   task automatic calc(input logic [15:0] e);
      @(posedge mclk);
      error_value <= e;
      calc_done   <= 1'b1;
      @(posedge mclk);
      calc_done   <= 1'b0;
      #1;
   endtask : calc

   // Threshold decision per mode, signed compare
   function automatic logic exp_irq(input logic [2:0] m,
                                    input logic signed [15:0] e);
      logic lt;
      logic gt;
      lt = e < $signed(LO);
      gt = e > $signed(UP);
      case (m)
         3'h0: exp_irq = 1'b0;
         3'h1: exp_irq = lt;
         3'h2: exp_irq = !lt;
         3'h3: exp_irq = (e > $signed(LO)) && (e < $signed(UP));
         3'h4: exp_irq = lt || gt;
         3'h5: exp_irq = !gt;
         3'h6: exp_irq = gt;
         default: exp_irq = 1'b1;
      endcase
   endfunction : exp_irq

   // Converter clock period in system clocks, skipping the first cycle
   task automatic period(output int q);
      int   k;
      int   r;
      int   t0;
      logic prev;
      q = 0;
      r = 0;
      t0 = 0;
      prev = conv_clk;
      for (k = 0; k < 400 && q == 0; k++) begin
         @(posedge mclk);
         #1;
         if (conv_clk === 1'b1 && prev === 1'b0) begin
            r++;
            if (r == 2) t0 = k;
            if (r == 3) q = k - t0;
         end
         prev = conv_clk;
      end
   endtask : period

   initial begin
      error_cnt = 0; n_compared = 0; cyc = 0; rc_clk_tick = 1'b0;
      reset = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'b00;
      hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0;
      error_value = 16'h0; calc_done = 1'b0; calc_start = 1'b0;
      overflow_evt = 1'b0; conv_trig = 1'b0;
      repeat (5) @(posedge mclk);
      reset <= 1'b0;
      // Reset values, idle stage, unmapped place
      xfer(ADCTS_IDX_STAT, 1'b0, 32'h0);
      chk(rd, 32'h0, "status reset");
      xfer(ADCTS_IDX_CLK, 1'b0, 32'h0);
      chk(rd, 32'h0, "divider reset");
      xfer(ADCTS_IDX_PCH, 1'b0, 32'h0);
      chk(rd, 32'h0, "channel reset");
      xfer(16'h1D00, 1'b1, 32'hFFFFFFFF);
      xfer(16'h1D00, 1'b0, 32'h0);
      chk(rd, 32'h0, "unmapped");
      chk({31'h0, hresp}, 32'h0, "hresp");
      // Update flag set by hardware, cleared by software
      @(posedge mclk) calc_start <= 1'b1;
      @(posedge mclk) calc_start <= 1'b0;
      xfer(ADCTS_IDX_STAT, 1'b0, 32'h0);
      chk(rd[4], 1'b1, "update set");
      xfer(ADCTS_IDX_STAT, 1'b1, 32'h0);
      xfer(ADCTS_IDX_STAT, 1'b0, 32'h0);
      chk(rd[4], 1'b0, "update clear");
      // Overflow sticks against software writes
      @(posedge mclk) overflow_evt <= 1'b1;
      @(posedge mclk) overflow_evt <= 1'b0;
      xfer(ADCTS_IDX_STAT, 1'b1, 32'h0);
      xfer(ADCTS_IDX_STAT, 1'b0, 32'h0);
      chk(rd[7], 1'b1, "overflow");
      // Every threshold mode against every test value
      xfer(ADCTS_IDX_LIM, 1'b1, {UP, LO});
      for (int m = 0; m < 8; m++) begin
         xfer(ADCTS_IDX_CTL, 1'b1, {29'h0, m[2:0]});
         foreach (tv[i]) begin
            calc(tv[i]);
            chk(threshold_irq, exp_irq(m[2:0], tv[i]), "irq");
            xfer(ADCTS_IDX_STAT, 1'b0, 32'h0);
            chk(rd[6:5], {$signed(tv[i]) > $signed(UP),
                          $signed(tv[i]) < $signed(LO)}, "flags");
         end
      end
      // Continuous run: stop-on-hit clears start, otherwise it stays
      xfer(ADCTS_IDX_CTL, 1'b1, 32'h2F);
      xfer(ADCTS_IDX_RUN, 1'b1, 32'h1);
      calc(16'h0);
      xfer(ADCTS_IDX_RUN, 1'b0, 32'h0);
      chk(rd[0], 1'b0, "stop on hit");
      xfer(ADCTS_IDX_CTL, 1'b1, 32'h27);
      xfer(ADCTS_IDX_RUN, 1'b1, 32'h1);
      calc(16'h0);
      xfer(ADCTS_IDX_RUN, 1'b0, 32'h0);
      chk(rd[0], 1'b1, "keeps running");
      xfer(ADCTS_IDX_RUN, 1'b1, 32'h0);
      // Reference codes; reserved 01 falls back to supply
      for (int c = 0; c < 4; c++) begin
         xfer(ADCTS_IDX_REF, 1'b1, {30'h0, c[1:0]});
         @(posedge mclk);  // Output flop lags the register by one edge
         #1;
         chk(ref_sel, (c == 1) ? 2'b00 : c[1:0], "reference");
      end
      // Channel decode, reserved codes flagged
      foreach (cc[i]) begin
         xfer(ADCTS_IDX_PCH, 1'b1, {26'h0, cc[i]});
         @(posedge mclk);  // Output flop lags the register by one edge
         #1;
         chk({chan_valid, chan_sel}, {cv[i], cc[i]}, "channel");
      end
      // Divider on the system clock, n of 0, 5 and 10
      xfer(ADCTS_IDX_CTL, 1'b1, 32'h0);
      foreach (cc[i]) begin
         if (i < 3) begin
            xfer(ADCTS_IDX_CLK, 1'b1, 32'h5 * i);
            period(p);
            chk(p, 2 * (5 * i + 1), "divider");
         end
      end
      // RC source selected: divider of 10 ignored, stand-in period is 2
      xfer(ADCTS_IDX_CTL, 1'b1, 32'h40);
      period(p);
      chk(p, 32'd2, "rc ignores divider");
      // Double sampling, single shot: suspend code, clear refused
      xfer(ADCTS_IDX_CLK, 1'b1, 32'h0);
      xfer(ADCTS_IDX_CTL, 1'b1, 32'h10);
      xfer(ADCTS_IDX_RUN, 1'b1, 32'h1);
      @(posedge mclk) conv_trig <= 1'b1;
      @(posedge mclk) conv_trig <= 1'b0;
      rd = 32'h0;
      for (int k = 0; k < 60 && rd[2:0] !== 3'b100; k++) begin
         xfer(ADCTS_IDX_STAT, 1'b0, 32'h0);
      end
      chk(rd[2:0], 3'b100, "suspended");
      @(posedge mclk) calc_start <= 1'b1;
      @(posedge mclk) calc_start <= 1'b0;
      xfer(ADCTS_IDX_STAT, 1'b1, 32'h0);
      xfer(ADCTS_IDX_STAT, 1'b0, 32'h0);
      chk(rd[4], 1'b1, "clear refused");
      xfer(ADCTS_IDX_RUN, 1'b1, 32'h0);
      print_verdict();
   end
endmodule : adc_threshold_status_control_bench
